// File: pkg/rrm_map.svh
// Purpose: register offsets, field positions and reset values of the reader register bank
// Assumes: 5-bit register address, 8-bit registers
// Notes: definitions only
`ifndef RRM_MAP_SVH
`define RRM_MAP_SVH

// host access word fields
`define RRM_AW_CMD_BIT 7
`define RRM_AW_READ_BIT 6
`define RRM_AW_CONT_BIT 5
`define RRM_AW_ADDR_MSB 4

// register offsets
`define RRM_CHIP_STATUS_CONTROL 5'h00
`define RRM_PROTOCOL_SELECT 5'h01
`define RRM_TX_PULSE_LENGTH 5'h06
`define RRM_RX_NO_RESPONSE_WAIT 5'h07
`define RRM_RX_WAIT_TIME 5'h08
`define RRM_MODULATOR_CLOCK_OUTPUT_CONTROL 5'h09
`define RRM_RX_SPECIAL_SETTING 5'h0A
`define RRM_REGULATOR_IO_CONTROL 5'h0B
`define RRM_INTERRUPT_STATUS 5'h0C
`define RRM_COLLISION_POSITION_IRQ_MASK 5'h0D
`define RRM_COLLISION_POSITION 5'h0E
`define RRM_SIGNAL_STRENGTH_OSC_STATUS 5'h0F
`define RRM_TEST_CONTROL_A 5'h1A
`define RRM_TEST_CONTROL_B 5'h1B
`define RRM_FIFO_STATUS 5'h1C
`define RRM_TX_LENGTH_HIGH 5'h1D
`define RRM_TX_LENGTH_LOW 5'h1E
`define RRM_FIFO_DATA_PORT 5'h1F

// chip status control fields
`define RRM_CSC_STANDBY 7
`define RRM_CSC_DIRECT 6
`define RRM_CSC_CARRIER_ON 5
`define RRM_CSC_HALF_POWER 4
`define RRM_CSC_AUX_INPUT 3
`define RRM_CSC_RX_FORCE 1
`define RRM_CSC_SUPPLY_HIGH 0

// protocol select fields
`define RRM_PS_DIRECT_TYPE 6

// reset values
`define RRM_CSC_RESET 8'h01
`define RRM_PS_RESET 8'h02
`define RRM_TXPL_RESET 8'h00
`define RRM_NORESP_RESET 8'h0E
`define RRM_OTHER_RESET 8'h00

`endif

// File: pkg/rrm_pkg.sv
// Purpose: types shared by the reader register bank
// Assumes: nothing
// Notes: offsets and values live in rrm_map.svh
package rrm_pkg;

  typedef logic [7:0] rrm_byte_t;
  typedef logic [4:0] rrm_addr_t;

  // host frame sequencer
  typedef enum logic [1:0] {
    RRM_ST_WORD,
    RRM_ST_WRITE,
    RRM_ST_READ,
    RRM_ST_SKIP
  } rrm_state_t;

endpackage

// File: src/rrm_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to ref_clk_i
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module rrm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

`default_nettype wire

// File: src/rrm_csc_decode.sv
// Purpose: turn chip status control and protocol select into front-end controls
// Assumes: register values from the bank on the same clock
// Notes: outputs registered, one cycle after the register changes
`timescale 1ns/1ps
`default_nettype none
`include "rrm_map.svh"

module rrm_csc_decode
  import rrm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // register values
  input wire rrm_byte_t csc_i,
  input wire rrm_byte_t proto_i,
  // front-end controls
  output logic standby_o,
  output logic direct_mode_o,
  output logic direct_mode_type_o,
  output logic carrier_output_enable_o,
  output logic receiver_enable_o,
  output logic tx_oscillator_enable_o,
  output logic half_power_select_o,
  output logic aux_input_select_o,
  output logic supply_range_high_o
);

  logic [8:0] ctl_d;
  logic [8:0] ctl_q;

  always_comb
  begin
    ctl_d[0] = csc_i[`RRM_CSC_STANDBY];
    ctl_d[1] = csc_i[`RRM_CSC_DIRECT];
    // type bit follows protocol select bit 6 every cycle, in or out of direct mode
    ctl_d[2] = proto_i[`RRM_PS_DIRECT_TYPE];
    ctl_d[3] = csc_i[`RRM_CSC_CARRIER_ON];
    // forced receive keeps the receiver alive with the carrier off
    ctl_d[4] = csc_i[`RRM_CSC_CARRIER_ON] | csc_i[`RRM_CSC_RX_FORCE];
    ctl_d[5] = csc_i[`RRM_CSC_CARRIER_ON] | csc_i[`RRM_CSC_RX_FORCE];
    ctl_d[6] = csc_i[`RRM_CSC_HALF_POWER];
    ctl_d[7] = csc_i[`RRM_CSC_AUX_INPUT];
    ctl_d[8] = csc_i[`RRM_CSC_SUPPLY_HIGH];
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctl_q <= 9'h100;
    end
    else
    begin
      ctl_q <= ctl_d;
    end
  end

  assign standby_o = ctl_q[0];
  assign direct_mode_o = ctl_q[1];
  assign direct_mode_type_o = ctl_q[2];
  assign carrier_output_enable_o = ctl_q[3];
  assign receiver_enable_o = ctl_q[4];
  assign tx_oscillator_enable_o = ctl_q[5];
  assign half_power_select_o = ctl_q[6];
  assign aux_input_select_o = ctl_q[7];
  assign supply_range_high_o = ctl_q[8];

endmodule

`default_nettype wire

// File: src/rrm_register_bank.sv
// Purpose: host-facing register bank of the reader front-end
// Assumes: host frames with select, marks each byte with a strobe rising edge
// Notes: all pins pass two flip-flops; enable pin low reloads the reset values
`timescale 1ns/1ps
`default_nettype none
`include "rrm_map.svh"

// How it works
// - chip status control takes 0x01 while enable is low or on power-on reset
// - bit 7 set gives standby with regulators and oscillator kept running
// - bit 6 set enters direct mode; clear keeps automatic framing
// - bit 5 set turns carrier transmitter and receivers on
// - bit 4 set selects half output power, higher output impedance
// - bit 3 set routes auxiliary receive input, clear the main input
// - bit 1 set forces receiver and transmit oscillator on
// - bit 0 set means 5-volt supply range, clear means 3-volt
// - 0x00, 0x01 and 0x06 to 0x0B are readable and writable
// - 0x0C and 0x0E read-only, 0x0D read-write
// - 0x0F returns signal strength and oscillator status, read-only
// - test 0x1A/0x1B rw, fifo status 0x1C ro, 0x1D/0x1E rw, 0x1F rw
// - access word: B7 zero is address mode, B6 read, B5 continuous, B4-B0 address
module rrm_register_bank
  import rrm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // chip enable pin, low holds the bank in reset
  input wire logic chip_enable_i,
  // host port pins
  input wire logic host_select_i,
  input wire logic host_strobe_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_o,
  // status from the analogue and framing side
  input wire rrm_byte_t interrupt_status_i,
  input wire rrm_byte_t collision_position_i,
  input wire rrm_byte_t signal_strength_level_i,
  input wire rrm_byte_t fifo_status_i,
  input wire rrm_byte_t fifo_rd_data_i,
  // fifo data port
  output logic fifo_wr_o,
  output logic fifo_rd_o,
  output rrm_byte_t fifo_wr_data_o,
  // register contents for the rest of the chip
  output rrm_byte_t protocol_select_o,
  output rrm_byte_t tx_pulse_length_o,
  output rrm_byte_t rx_no_response_wait_o,
  output rrm_byte_t rx_wait_time_o,
  output rrm_byte_t modulator_clock_output_control_o,
  output rrm_byte_t rx_special_setting_o,
  output rrm_byte_t regulator_io_control_o,
  output rrm_byte_t irq_mask_o,
  output rrm_byte_t test_control_a_o,
  output rrm_byte_t test_control_b_o,
  output rrm_byte_t tx_length_high_o,
  output rrm_byte_t tx_length_low_o,
  // chip status control decode
  output logic standby_o,
  output logic direct_mode_o,
  output logic direct_mode_type_o,
  output logic carrier_output_enable_o,
  output logic receiver_enable_o,
  output logic tx_oscillator_enable_o,
  output logic half_power_select_o,
  output logic aux_input_select_o,
  output logic supply_range_high_o
);

  // addresses that keep a stored byte; the fifo port streams instead
  function automatic logic is_stored(input rrm_addr_t a);
    unique case (a)
      `RRM_CHIP_STATUS_CONTROL, `RRM_PROTOCOL_SELECT,
      `RRM_TX_PULSE_LENGTH, `RRM_RX_NO_RESPONSE_WAIT,
      `RRM_RX_WAIT_TIME, `RRM_MODULATOR_CLOCK_OUTPUT_CONTROL,
      `RRM_RX_SPECIAL_SETTING, `RRM_REGULATOR_IO_CONTROL: is_stored = 1'b1;
      `RRM_COLLISION_POSITION_IRQ_MASK: is_stored = 1'b1;
      `RRM_TEST_CONTROL_A, `RRM_TEST_CONTROL_B,
      `RRM_TX_LENGTH_HIGH, `RRM_TX_LENGTH_LOW: is_stored = 1'b1;
      default: is_stored = 1'b0;
    endcase
  endfunction

  function automatic rrm_byte_t reset_val(input rrm_addr_t a);
    unique case (a)
      `RRM_CHIP_STATUS_CONTROL: reset_val = `RRM_CSC_RESET;
      `RRM_PROTOCOL_SELECT: reset_val = `RRM_PS_RESET;
      `RRM_TX_PULSE_LENGTH: reset_val = `RRM_TXPL_RESET;
      `RRM_RX_NO_RESPONSE_WAIT: reset_val = `RRM_NORESP_RESET;
      default: reset_val = `RRM_OTHER_RESET;
    endcase
  endfunction

  // synchronised pins
  logic en_s;
  logic sel_s;
  logic stb_s;
  rrm_byte_t data_s;
  logic stb_prev_q;
  logic stb_rise;

  rrm_sync #(
    .W(11),
    .INIT(11'h000)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .d_i({chip_enable_i, host_select_i, host_strobe_i, host_data_i}),
    .q_o({en_s, sel_s, stb_s, data_s})
  );

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stb_prev_q <= 1'b0;
    end
    else
    begin
      stb_prev_q <= stb_s;
    end
  end

  assign stb_rise = stb_s & ~stb_prev_q;

  // sequencer and register state
  rrm_state_t state_q;
  rrm_state_t state_d;
  rrm_addr_t addr_q;
  rrm_addr_t addr_d;
  logic cont_q;
  logic cont_d;
  rrm_byte_t regs_q [32];
  rrm_byte_t regs_d [32];
  rrm_byte_t rd_data_q;
  rrm_byte_t rd_data_d;
  rrm_byte_t rd_val;
  logic fifo_wr_q;
  logic fifo_wr_d;
  logic fifo_rd_q;
  logic fifo_rd_d;
  rrm_byte_t fifo_wdata_q;
  rrm_byte_t fifo_wdata_d;

  // read multiplexer: live status for read-only addresses and the fifo port, stored byte for stored addresses, zero elsewhere
  always_comb
  begin
    unique case (addr_q)
      `RRM_INTERRUPT_STATUS: rd_val = interrupt_status_i;
      `RRM_COLLISION_POSITION: rd_val = collision_position_i;
      `RRM_SIGNAL_STRENGTH_OSC_STATUS: rd_val = signal_strength_level_i;
      `RRM_FIFO_STATUS: rd_val = fifo_status_i;
      `RRM_FIFO_DATA_PORT: rd_val = fifo_rd_data_i;
      default: rd_val = is_stored(addr_q) ? regs_q[addr_q] : 8'h00;
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    addr_d = addr_q;
    cont_d = cont_q;
    regs_d = regs_q;
    rd_data_d = rd_data_q;
    fifo_wr_d = 1'b0;
    fifo_rd_d = 1'b0;
    fifo_wdata_d = fifo_wdata_q;
    if (state_q == RRM_ST_READ)
    begin
      rd_data_d = rd_val;
    end
    if (!sel_s)
    begin
      state_d = RRM_ST_WORD;
    end
    else if (stb_rise)
    begin
      unique case (state_q)
        RRM_ST_WORD:
        begin
          // command words belong to the command decoder, not the bank
          if (data_s[`RRM_AW_CMD_BIT])
          begin
            state_d = RRM_ST_SKIP;
          end
          else
          begin
            addr_d = data_s[`RRM_AW_ADDR_MSB:0];
            cont_d = data_s[`RRM_AW_CONT_BIT];
            state_d = data_s[`RRM_AW_READ_BIT] ? RRM_ST_READ : RRM_ST_WRITE;
          end
        end
        RRM_ST_WRITE:
        begin
          // read-only and unmapped addresses drop the byte
          if (is_stored(addr_q))
          begin
            regs_d[addr_q] = data_s;
          end
          if (addr_q == `RRM_FIFO_DATA_PORT)
          begin
            fifo_wr_d = 1'b1;
            fifo_wdata_d = data_s;
          end
          addr_d = addr_q + 5'h01;
          state_d = cont_q ? RRM_ST_WRITE : RRM_ST_SKIP;
        end
        RRM_ST_READ:
        begin
          // strobe marks the byte as taken by the host
          fifo_rd_d = (addr_q == `RRM_FIFO_DATA_PORT);
          addr_d = addr_q + 5'h01;
          state_d = cont_q ? RRM_ST_READ : RRM_ST_SKIP;
        end
        RRM_ST_SKIP:
        begin
          state_d = RRM_ST_SKIP;
        end
      endcase
    end
    // enable low acts as a held reset of every stored register
    if (!en_s)
    begin
      state_d = RRM_ST_WORD;
      fifo_wr_d = 1'b0;
      fifo_rd_d = 1'b0;
      for (int i = 0; i < 32; i++)
      begin
        regs_d[i] = reset_val(5'(i));
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= RRM_ST_WORD;
      addr_q <= 5'h00;
      cont_q <= 1'b0;
      rd_data_q <= 8'h00;
      fifo_wr_q <= 1'b0;
      fifo_rd_q <= 1'b0;
      fifo_wdata_q <= 8'h00;
      for (int i = 0; i < 32; i++)
      begin
        regs_q[i] <= reset_val(5'(i));
      end
    end
    else
    begin
      state_q <= state_d;
      addr_q <= addr_d;
      cont_q <= cont_d;
      rd_data_q <= rd_data_d;
      fifo_wr_q <= fifo_wr_d;
      fifo_rd_q <= fifo_rd_d;
      fifo_wdata_q <= fifo_wdata_d;
      regs_q <= regs_d;
    end
  end

  // host pins: drive the bus only while a read frame is open
  assign host_data_o = rd_data_q;
  assign host_data_oe_o = (state_q == RRM_ST_READ) & sel_s;

  assign fifo_wr_o = fifo_wr_q;
  assign fifo_rd_o = fifo_rd_q;
  assign fifo_wr_data_o = fifo_wdata_q;

  assign protocol_select_o = regs_q[`RRM_PROTOCOL_SELECT];
  assign tx_pulse_length_o = regs_q[`RRM_TX_PULSE_LENGTH];
  assign rx_no_response_wait_o = regs_q[`RRM_RX_NO_RESPONSE_WAIT];
  assign rx_wait_time_o = regs_q[`RRM_RX_WAIT_TIME];
  assign modulator_clock_output_control_o = regs_q[`RRM_MODULATOR_CLOCK_OUTPUT_CONTROL];
  assign rx_special_setting_o = regs_q[`RRM_RX_SPECIAL_SETTING];
  assign regulator_io_control_o = regs_q[`RRM_REGULATOR_IO_CONTROL];
  assign irq_mask_o = regs_q[`RRM_COLLISION_POSITION_IRQ_MASK];
  assign test_control_a_o = regs_q[`RRM_TEST_CONTROL_A];
  assign test_control_b_o = regs_q[`RRM_TEST_CONTROL_B];
  assign tx_length_high_o = regs_q[`RRM_TX_LENGTH_HIGH];
  assign tx_length_low_o = regs_q[`RRM_TX_LENGTH_LOW];

  rrm_csc_decode u_csc (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .csc_i(regs_q[`RRM_CHIP_STATUS_CONTROL]),
    .proto_i(regs_q[`RRM_PROTOCOL_SELECT]),
    .standby_o(standby_o),
    .direct_mode_o(direct_mode_o),
    .direct_mode_type_o(direct_mode_type_o),
    .carrier_output_enable_o(carrier_output_enable_o),
    .receiver_enable_o(receiver_enable_o),
    .tx_oscillator_enable_o(tx_oscillator_enable_o),
    .half_power_select_o(half_power_select_o),
    .aux_input_select_o(aux_input_select_o),
    .supply_range_high_o(supply_range_high_o)
  );

endmodule

`default_nettype wire

// File: bench/rrm_host_model.sv
// Purpose: host controller model driving the frame port
// Assumes: strobe high 4 cycles and low 4, data held across the strobe
// Notes: when released, data lines show the inverted last byte
`timescale 1ns/1ps
`default_nettype none
module rrm_host_model (
  // clock
  input wire logic ref_clk_i,
  // frame pins
  output logic host_select_o,
  output logic host_strobe_o,
  output logic [7:0] host_drv_o,
  // resolved data wire
  input wire logic [7:0] host_bus_i
);
  initial
  begin
    host_select_o = 1'b0;
    host_strobe_o = 1'b0;
    host_drv_o = 8'h00;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic open_frame();
    host_select_o = 1'b1;
    wait_clk(2);
  endtask
  // data stays put well past the synchroniser delay
  task automatic put(input logic [7:0] b);
    host_drv_o = b;
    wait_clk(2);
    host_strobe_o = 1'b1;
    wait_clk(4);
    host_strobe_o = 1'b0;
    wait_clk(4);
  endtask
  // sample the byte, then strobe to take it
  task automatic get(output logic [7:0] b);
    b = host_bus_i;
    put(host_drv_o);
  endtask
  task automatic close_frame();
    host_select_o = 1'b0;
    host_drv_o = ~host_drv_o;
    wait_clk(4);
  endtask
endmodule
`default_nettype wire

// File: bench/rrm_register_bank_checker.sv
// Purpose: port assertions for the reader register bank
// Assumes: pins pass a 2-3 cycle synchroniser
// Notes: bound to rrm_register_bank
`timescale 1ns/1ps
`default_nettype none
module rrm_register_bank_checker
  import rrm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // pins
  input wire logic chip_enable_i,
  input wire logic host_select_i,
  input wire logic host_data_oe_o,
  // outputs
  input wire logic fifo_wr_o,
  input wire logic fifo_rd_o,
  input wire rrm_byte_t protocol_select_o,
  input wire rrm_byte_t rx_no_response_wait_o,
  input wire logic standby_o,
  input wire logic direct_mode_o,
  input wire logic direct_mode_type_o,
  input wire logic carrier_output_enable_o,
  input wire logic receiver_enable_o,
  input wire logic tx_oscillator_enable_o,
  input wire logic supply_range_high_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  chk_en_low_regs: assert property (
    !chip_enable_i [*6] |-> protocol_select_o == 8'h02 && rx_no_response_wait_o == 8'h0E)
    else $error("bank not reloaded while enable low");
  chk_en_low_dec: assert property (
    !chip_enable_i [*7] |-> supply_range_high_o && !standby_o && !direct_mode_o
    && !carrier_output_enable_o) else $error("control decode not at reset");
  chk_carrier_rx: assert property (
    carrier_output_enable_o |-> receiver_enable_o) else $error("carrier on, receiver off");
  chk_rx_osc_pair: assert property (
    receiver_enable_o == tx_oscillator_enable_o) else $error("receiver and oscillator differ");
  chk_oe_select: assert property (
    host_data_oe_o |-> $past(host_select_i, 2)) else $error("drive without select");
  chk_oe_idle: assert property (
    !host_select_i [*4] |-> !host_data_oe_o) else $error("drive after select dropped");
  chk_fifo_wr_pulse: assert property (
    fifo_wr_o |=> !fifo_wr_o) else $error("fifo push longer than one cycle");
  chk_fifo_rd_pulse: assert property (
    fifo_rd_o |=> !fifo_rd_o) else $error("fifo pop longer than one cycle");
  chk_fifo_wr_frame: assert property (
    fifo_wr_o |-> $past(host_select_i, 3)) else $error("fifo push outside a frame");
  chk_dtype_follow: assert property (
    $rose(protocol_select_o[6]) |=> direct_mode_type_o) else $error("direct type not decoded");
  cover property (fifo_wr_o);
  cover property (fifo_rd_o);
  cover property (host_data_oe_o);
  cover property (direct_mode_o && direct_mode_type_o);
endmodule
bind rrm_register_bank rrm_register_bank_checker chk_u (.ref_clk_i(ref_clk_i),
  .arst_n_i(arst_n_i), .chip_enable_i(chip_enable_i), .host_select_i(host_select_i),
  .host_data_oe_o(host_data_oe_o), .fifo_wr_o(fifo_wr_o), .fifo_rd_o(fifo_rd_o),
  .protocol_select_o(protocol_select_o), .rx_no_response_wait_o(rx_no_response_wait_o),
  .standby_o(standby_o), .direct_mode_o(direct_mode_o),
  .direct_mode_type_o(direct_mode_type_o), .carrier_output_enable_o(carrier_output_enable_o),
  .receiver_enable_o(receiver_enable_o), .tx_oscillator_enable_o(tx_oscillator_enable_o),
  .supply_range_high_o(supply_range_high_o));
`default_nettype wire

// File: bench/rrm_register_bank_tb.sv
// Purpose: self-checking bench for the reader register bank
// Assumes: 50 MHz clock, host model on the frame port
// Notes: expected values come from a byte-array model
`timescale 1ns/1ps
`default_nettype none
module rrm_register_bank_tb
  import rrm_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic chip_enable_i = 1'b0;
  logic host_select_i, host_strobe_i, host_data_oe_o, fifo_wr_o, fifo_rd_o;
  logic [7:0] host_data_o, hdrv;
  // status inputs get random values once the seed is set, and new ones at the start of every rd frame
  rrm_byte_t interrupt_status_i, collision_position_i;
  rrm_byte_t signal_strength_level_i, fifo_status_i, fifo_rd_data_i;
  rrm_byte_t fifo_wr_data_o, protocol_select_o, tx_pulse_length_o, rx_no_response_wait_o;
  rrm_byte_t rx_wait_time_o, modulator_clock_output_control_o, rx_special_setting_o;
  rrm_byte_t regulator_io_control_o, irq_mask_o, test_control_a_o, test_control_b_o;
  rrm_byte_t tx_length_high_o, tx_length_low_o;
  logic standby_o, direct_mode_o, direct_mode_type_o, carrier_output_enable_o;
  logic receiver_enable_o, tx_oscillator_enable_o, half_power_select_o;
  logic aux_input_select_o, supply_range_high_o;
  // device drives the wire only while its enable is up
  wire logic [7:0] host_data_i = host_data_oe_o ? host_data_o : hdrv;
  logic [7:0] mdl [32];
  logic [7:0] fwd = 8'h00;
  int ra [12] = '{1, 6, 7, 8, 9, 10, 11, 13, 26, 27, 29, 30};
  int miscompares, comparisons, n_wr, n_rd, n_wr_exp, n_rd_exp;
  rrm_register_bank dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .chip_enable_i(chip_enable_i), .host_select_i(host_select_i),
    .host_strobe_i(host_strobe_i), .host_data_i(host_data_i), .host_data_o(host_data_o),
    .host_data_oe_o(host_data_oe_o), .interrupt_status_i(interrupt_status_i),
    .collision_position_i(collision_position_i),
    .signal_strength_level_i(signal_strength_level_i), .fifo_status_i(fifo_status_i),
    .fifo_rd_data_i(fifo_rd_data_i), .fifo_wr_o(fifo_wr_o), .fifo_rd_o(fifo_rd_o),
    .fifo_wr_data_o(fifo_wr_data_o), .protocol_select_o(protocol_select_o),
    .tx_pulse_length_o(tx_pulse_length_o), .rx_no_response_wait_o(rx_no_response_wait_o),
    .rx_wait_time_o(rx_wait_time_o),
    .modulator_clock_output_control_o(modulator_clock_output_control_o),
    .rx_special_setting_o(rx_special_setting_o),
    .regulator_io_control_o(regulator_io_control_o), .irq_mask_o(irq_mask_o),
    .test_control_a_o(test_control_a_o), .test_control_b_o(test_control_b_o),
    .tx_length_high_o(tx_length_high_o), .tx_length_low_o(tx_length_low_o),
    .standby_o(standby_o), .direct_mode_o(direct_mode_o),
    .direct_mode_type_o(direct_mode_type_o),
    .carrier_output_enable_o(carrier_output_enable_o),
    .receiver_enable_o(receiver_enable_o), .tx_oscillator_enable_o(tx_oscillator_enable_o),
    .half_power_select_o(half_power_select_o), .aux_input_select_o(aux_input_select_o),
    .supply_range_high_o(supply_range_high_o));
  rrm_host_model host_u (.ref_clk_i(ref_clk_i), .host_select_o(host_select_i),
    .host_strobe_o(host_strobe_i), .host_drv_o(hdrv), .host_bus_i(host_data_i));
  initial
  begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // count mid-cycle, well clear of the edge that launches each pulse
  always @(negedge ref_clk_i)
  begin
    if (fifo_wr_o === 1'b1) n_wr++;
    if (fifo_rd_o === 1'b1) n_rd++;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_dec(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t decode got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic mdl_reset();
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[0] = 8'h01;
    mdl[1] = 8'h02;
    mdl[7] = 8'h0E;
  endtask
  function automatic logic [7:0] exp_rd(input int a);
    case (a)
      12: return interrupt_status_i;
      14: return collision_position_i;
      15: return signal_strength_level_i;
      28: return fifo_status_i;
      31: return fifo_rd_data_i;
      default: return mdl[a];
    endcase
  endfunction
  task automatic chk_regs();
    logic [7:0] o [12];
    o = '{protocol_select_o, tx_pulse_length_o, rx_no_response_wait_o, rx_wait_time_o,
      modulator_clock_output_control_o, rx_special_setting_o, regulator_io_control_o,
      irq_mask_o, test_control_a_o, test_control_b_o, tx_length_high_o, tx_length_low_o};
    foreach (o[i]) cmp(o[i], mdl[ra[i]]);
  endtask
  task automatic chk_dec();
    logic [7:0] c;
    c = mdl[0];
    cmp_dec({standby_o, direct_mode_o, direct_mode_type_o, carrier_output_enable_o,
      receiver_enable_o, tx_oscillator_enable_o, half_power_select_o, aux_input_select_o,
      supply_range_high_o}, {c[7], c[6], mdl[1][6], c[5], c[5] | c[1], c[5] | c[1], c[4],
      c[3], c[0]});
  endtask
  // only mapped writable places keep a written byte
  task automatic wr(input int a, input int n, input bit cont, input logic [7:0] v0);
    logic [7:0] v;
    int j;
    host_u.open_frame();
    host_u.put({2'b00, cont, 5'(a)});
    for (int i = 0; i < n; i++)
    begin
      v = (i == 0) ? v0 : 8'($urandom);
      host_u.put(v);
      j = (a + i) % 32;
      if ((i == 0 || cont) && j inside {[0:1], [6:11], 13, 26, 27, 29, 30}) mdl[j] = v;
      if ((i == 0 || cont) && j == 31)
      begin
        fwd = v;
        n_wr_exp++;
      end
    end
    host_u.close_frame();
  endtask
  task automatic rd(input int a, input int n, input bit cont);
    logic [7:0] g;
    {interrupt_status_i, collision_position_i, signal_strength_level_i, fifo_status_i} = $urandom;
    fifo_rd_data_i = 8'($urandom);
    host_u.open_frame();
    host_u.put({2'b01, cont, 5'(a)});
    for (int i = 0; i < n; i++)
    begin
      host_u.get(g);
      cmp(g, exp_rd((a + i) % 32));
      if ((a + i) % 32 == 31) n_rd_exp++;
    end
    host_u.close_frame();
  endtask
  task automatic restart();
    mdl_reset();
    host_u.wait_clk(10);
    chk_regs();
    chk_dec();
    rd(0, 32, 1);
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(79627));
    {interrupt_status_i, collision_position_i, signal_strength_level_i, fifo_status_i} = $urandom;
    fifo_rd_data_i = 8'($urandom);
    repeat (5) @(posedge ref_clk_i);
    #1;
    arst_n_i = 1'b1;
    chip_enable_i = 1'b1;
    restart();
    for (int k = 0; k < 3; k++)
    begin
      wr(k * 11, 32, 1, 8'($urandom));
      chk_regs();
      rd(k * 11 + 5, 32, 1);
    end
    cmp(fifo_wr_data_o, fwd);
    for (int k = 0; k < 8; k++)
    begin
      wr(1, 1, 0, (k == 6) ? 8'h40 : 8'h02);
      wr(0, 1, 0, 8'h01 << k);
      host_u.wait_clk(2);
      chk_dec();
    end
    wr(8, 3, 0, 8'h5A);
    host_u.open_frame();
    host_u.put(8'h8F);
    host_u.put(8'hA5);
    host_u.close_frame();
    chk_regs();
    rd(12, 1, 0);
    cmp(8'(n_wr), 8'(n_wr_exp));
    cmp(8'(n_rd), 8'(n_rd_exp));
    chip_enable_i = 1'b0;
    host_u.wait_clk(10);
    chip_enable_i = 1'b1;
    restart();
    wr(0, 1, 0, 8'hBE);
    arst_n_i = 1'b0;
    host_u.wait_clk(2);
    arst_n_i = 1'b1;
    restart();
    finish_test();
  end
  initial
  begin
    // the full run needs about 4000 cycles; allow roughly five times that
    #400000;
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
